// file: design/pcsu_top.sv
// Upper PCI configuration registers with strap-controlled fields and decoders
`timescale 1ns/100ps
`include "pcsu_cfg.svh"

// Function
// - MMIO address is offset[31:10] plus port[9:0]
// - Relocatable 1K-byte I/O base matches AD[15:10]
// - Relocation enable bit is read-only strap copy
// - ROM base bits 31:16 locate 64K block
// - ROM strap loads base bits 19:18 ones
// - Bit 15 selects 32K only with strap
// - ROM enable read/write only with strap
// - ROM enable decodes C0000 and blocks DRAM
// - Interrupt pin field reads 01h without strap
// - Interrupt strap clears pin bit, disables request
// - Interrupt line is plain scratch byte
// - Registers decode at 14, 2C, 30, 3C
// - MMIO strap makes offset 31:10 writable
module pcsu_top
  import pcsu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_valid,
  input  wire logic        ext_write_enable,
  input  wire logic        reloc_io_strap_pin,
  input  wire logic        mmio_strap_pin,
  input  wire logic        rom_present_strap_pin,
  input  wire logic        rom_size_strap_pin,
  input  wire logic        interrupt_strap_pin,
  input  wire logic [15:0] io_port_addr,
  input  wire logic [31:0] mem_addr,
  input  wire logic        irq_request,
  output logic [31:0]      mmio_mem_addr,
  output logic             reloc_io_hit,
  output logic             rom_window_hit,
  output logic             rom_base_hit,
  output logic             dram_cas_we_block,
  output logic             rom_bus_select,
  output logic             interrupt_request_out,
  output logic             interrupt_request_out_oe_n,
  output logic [7:0]       strap_latch_register
);

  pcsu_strap_if  straps ();
  pcsu_reg_sel_t sel;
  logic [31:0]   reloc_q;
  logic [31:0]   subsys_q;
  logic [31:0]   rom_q;
  logic [7:0]    int_line_q;
  logic [31:0]   reloc_wm;
  logic [31:0]   rom_wm;
  logic [31:0]   subsys_wm;
  logic [31:0]   reloc_rd;
  logic [31:0]   rom_rd;
  logic [31:0]   int_rd;
  logic [31:0]   next_rdata;
  logic          int_pin_bit;
  logic          reloc_active;
  logic          rom_enable;

  pcsu_strap_latch pcsu_strap_latch_inst (
    .clk                   (clk),
    .reset                 (reset),
    .reloc_io_strap_pin    (reloc_io_strap_pin),
    .mmio_strap_pin        (mmio_strap_pin),
    .rom_present_strap_pin (rom_present_strap_pin),
    .rom_size_strap_pin    (rom_size_strap_pin),
    .interrupt_strap_pin   (interrupt_strap_pin),
    .straps                (straps.source)
  );

  // Byte-lane merge limited to the writable bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old_v & ~m) | (wd & m);
  endfunction

  // Offset decode
  always_comb
  begin
    case (cfg_addr)
      `PCSU_OFF_RELOC:  sel = PCSU_SEL_RELOC;
      `PCSU_OFF_SUBSYS: sel = PCSU_SEL_SUBSYS;
      `PCSU_OFF_ROM:    sel = PCSU_SEL_ROM;
      `PCSU_OFF_INT:    sel = PCSU_SEL_INT;
      default:          sel = PCSU_SEL_NONE;
    endcase
  end

  // Writable masks set by the straps and by ext_write_enable
  assign reloc_wm  = straps.mmio ? `PCSU_RELOC_MMIO_WM : `PCSU_RELOC_BASE_WM;
  assign rom_wm    = `PCSU_ROM_BASE_WM
                   | (straps.rom_32k ? `PCSU_ROM_32K_WM : `PCSU_RST_ZERO)
                   | (straps.rom_present ? `PCSU_ROM_EN_WM : `PCSU_RST_ZERO);
  assign subsys_wm = ext_write_enable ? `PCSU_ALL_WM : `PCSU_RST_ZERO;

  // Pin bit reads 1 unless the interrupt strap was present
  assign int_pin_bit  = ~straps.int_dis;
  assign rom_enable   = rom_q[`PCSU_ROM_EN_BIT];
  assign reloc_active = straps.reloc_en & ~straps.mmio;

  // Read views; low bits 9:1 and 14:1 reserved read zero
  assign reloc_rd = {reloc_q[31:10], 9'h000, straps.reloc_en};
  assign rom_rd   = {rom_q[31:15], 14'h0000, rom_q[`PCSU_ROM_EN_BIT]};
  assign int_rd   = {16'h0000, 7'h00, int_pin_bit, int_line_q};

  // Offset relocation register
  always_ff @(posedge clk)
  begin
    if (reset)
      reloc_q <= `PCSU_RST_ZERO;
    else if (cfg_wr && sel == PCSU_SEL_RELOC)
      reloc_q <= merge(reloc_q, cfg_wdata, cfg_be, reloc_wm);
  end

  // Subsystem identifiers, locked unless extension writes are enabled
  always_ff @(posedge clk)
  begin
    if (reset)
      subsys_q <= `PCSU_RST_ZERO;
    else if (cfg_wr && sel == PCSU_SEL_SUBSYS)
      subsys_q <= merge(subsys_q, cfg_wdata, cfg_be, subsys_wm);
  end

  // ROM base; pin sampled directly since reset here is synchronous
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rom_q        <= `PCSU_RST_ZERO;
      rom_q[19:18] <= rom_present_strap_pin ? `PCSU_ROM_STRAP_RST : 2'h0;
    end
    else if (cfg_wr && sel == PCSU_SEL_ROM)
      rom_q <= merge(rom_q, cfg_wdata, cfg_be, rom_wm);
  end

  // Interrupt line scratch byte, no effect on the block
  always_ff @(posedge clk)
  begin
    if (reset)
      int_line_q <= 8'h00;
    else if (cfg_wr && sel == PCSU_SEL_INT && cfg_be[0])
      int_line_q <= cfg_wdata[7:0];
  end

  // Read mux; unmapped offsets return zero
  always_comb
  begin
    case (sel)
      PCSU_SEL_RELOC:  next_rdata = reloc_rd;
      PCSU_SEL_SUBSYS: next_rdata = subsys_q;
      PCSU_SEL_ROM:    next_rdata = rom_rd;
      PCSU_SEL_INT:    next_rdata = int_rd;
      default:         next_rdata = `PCSU_RST_ZERO;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_rdata    <= `PCSU_RST_ZERO;
      cfg_rd_valid <= 1'b0;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= next_rdata;
    end
  end

  // Memory-mapped I/O address: port bits 15:10 replaced by offset bits 31:10
  always_ff @(posedge clk)
  begin
    if (reset)
      mmio_mem_addr <= `PCSU_RST_ZERO;
    else
      mmio_mem_addr <= {reloc_q[31:10], io_port_addr[9:0]};
  end

  // Relocatable I/O range decode on AD[15:10]
  always_ff @(posedge clk)
  begin
    if (reset)
      reloc_io_hit <= 1'b0;
    else
      reloc_io_hit <= reloc_active && io_port_addr[15:10] == reloc_q[15:10];
  end

  // ROM decode; 32K mode widens the compare to bit 15
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rom_window_hit <= 1'b0;
      rom_base_hit   <= 1'b0;
    end
    else
    begin
      rom_window_hit <= rom_enable && mem_addr[31:16] == `PCSU_ROM_WIN_SEG;
      if (rom_q[`PCSU_ROM_32K_BIT])
        rom_base_hit <= rom_enable && mem_addr[31:15] == rom_q[31:15];
      else
        rom_base_hit <= rom_enable && mem_addr[31:16] == rom_q[31:16];
    end
  end

  // ROM enable takes over the memory pins and holds CAS/WE high
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dram_cas_we_block <= 1'b0;
      rom_bus_select    <= 1'b0;
    end
    else
    begin
      dram_cas_we_block <= rom_enable;
      rom_bus_select    <= rom_enable;
    end
  end

  // Open-drain request; never driven while the pin bit is cleared
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      interrupt_request_out      <= 1'b0;
      interrupt_request_out_oe_n <= 1'b1;
    end
    else
    begin
      interrupt_request_out      <= 1'b0;
      interrupt_request_out_oe_n <= ~(irq_request & int_pin_bit);
    end
  end

  // Strap latch view for the extension register block
  always_ff @(posedge clk)
  begin
    strap_latch_register <= {straps.mmio, 2'h0, straps.rom_present,
                             straps.rom_32k, 1'b0, straps.int_dis, 1'b0};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_MMIO_ADDR: assert property (1'b1 |=> mmio_mem_addr ==
    {$past(reloc_q[31:10]), $past(io_port_addr[9:0])})
    else $error("mmio address not built from offset and port");
  AST_RELOC_HIT: assert property (reloc_io_hit |->
    $past(reloc_active) && $past(io_port_addr[15:10]) == $past(reloc_q[15:10]))
    else $error("relocatable I/O hit without enable or match");
  AST_RELOC_EN_RO: assert property (cfg_rd && sel == PCSU_SEL_RELOC |=>
    cfg_rd_valid && cfg_rdata[0] == straps.reloc_en)
    else $error("relocation enable bit does not follow strap");
  AST_SUBSYS_LOCK: assert property (!ext_write_enable |=> $stable(subsys_q))
    else $error("subsystem id changed while locked");
  AST_ROM_STRAP_LOAD: assert property ($fell(reset) |->
    rom_q[19:18] == {2{straps.rom_present}})
    else $error("rom base 19:18 not loaded from strap");
  AST_ROM_32K_RO: assert property (!straps.rom_32k |-> !rom_q[15])
    else $error("32K bit set without strap");
  AST_ROM_EN_RO: assert property (!straps.rom_present |-> !rom_enable)
    else $error("rom enable set without strap");
  AST_ROM_BLOCK: assert property (rom_enable ##1 rom_enable |->
    dram_cas_we_block && rom_bus_select)
    else $error("rom enabled but display memory not blocked");
  AST_INT_PIN: assert property (cfg_rd && sel == PCSU_SEL_INT |=>
    cfg_rdata[15:8] == {7'h00, ~straps.int_dis})
    else $error("interrupt pin field wrong");
  AST_INT_GATE: assert property (straps.int_dis |=> interrupt_request_out_oe_n)
    else $error("interrupt driven while disabled by strap");
  AST_UNMAPPED: assert property (cfg_rd && sel == PCSU_SEL_NONE |=>
    cfg_rdata == 32'h00000000)
    else $error("unmapped offset returned data");

  // Write path and decode checks
  AST_INT_LINE: assert property (cfg_wr && sel == PCSU_SEL_INT && cfg_be[0] |=>
    int_line_q == $past(cfg_wdata[7:0]))
    else $error("interrupt line byte not written");
  AST_ROM_WIN: assert property (rom_window_hit |->
    $past(rom_enable) && $past(mem_addr[31:16]) == `PCSU_ROM_WIN_SEG)
    else $error("rom window hit without enable or match");
  AST_RELOC_HI_RO: assert property (!straps.mmio |-> reloc_q[31:16] == 16'h0000)
    else $error("offset bits 31:16 written without mmio strap");
  AST_ROM_BASE: assert property (rom_base_hit |-> $past(rom_enable))
    else $error("rom base hit while rom disabled");

endmodule // pcsu_top

// file: design/pcsu_cfg.svh
// Offsets, field positions, reset values and decode constants of the config block
`ifndef PCSU_CFG_SVH
`define PCSU_CFG_SVH

// Configuration offsets (byte addresses)
`define PCSU_OFF_RELOC      8'h14
`define PCSU_OFF_SUBSYS     8'h2c
`define PCSU_OFF_ROM        8'h30
`define PCSU_OFF_INT        8'h3c

// Writable masks per register
`define PCSU_RELOC_MMIO_WM  32'hfffffc00
`define PCSU_RELOC_BASE_WM  32'h0000fc00
`define PCSU_ROM_BASE_WM    32'hffff0000
`define PCSU_ROM_32K_WM     32'h00008000
`define PCSU_ROM_EN_WM      32'h00000001
`define PCSU_INT_LINE_WM    32'h000000ff
`define PCSU_ALL_WM         32'hffffffff

// Field positions
`define PCSU_ROM_32K_BIT    15
`define PCSU_ROM_EN_BIT     0
`define PCSU_INT_PIN_BIT    8

// Strap latch register bit positions
`define PCSU_SL_MMIO_BIT    7
`define PCSU_SL_ROM_BIT     4
`define PCSU_SL_32K_BIT     3
`define PCSU_SL_INT_BIT     1

// Reset values
`define PCSU_RST_ZERO       32'h00000000
`define PCSU_ROM_STRAP_RST  2'h3

// Legacy ROM window, address bits 31:16
`define PCSU_ROM_WIN_SEG    16'h000c

`endif

// file: design/pcsu_pkg.sv
// Types shared by the config block modules
package pcsu_pkg;

  // Register select, one-hot
  typedef enum logic [4:0] {
    PCSU_SEL_NONE   = 5'h01,
    PCSU_SEL_RELOC  = 5'h02,
    PCSU_SEL_SUBSYS = 5'h04,
    PCSU_SEL_ROM    = 5'h08,
    PCSU_SEL_INT    = 5'h10
  } pcsu_reg_sel_t;

endpackage

// file: design/pcsu_strap_if.sv
// Latched strap levels passed from the strap latch to the register logic
`timescale 1ns/100ps
interface pcsu_strap_if;
  logic reloc_en;
  logic mmio;
  logic rom_present;
  logic rom_32k;
  logic int_dis;

  modport source (output reloc_en, output mmio, output rom_present,
                  output rom_32k, output int_dis);
  modport user   (input reloc_en, input mmio, input rom_present,
                  input rom_32k, input int_dis);
endinterface

// file: design/pcsu_strap_latch.sv
// Strap sampler that holds pin levels from reset to the next reset
`timescale 1ns/100ps
module pcsu_strap_latch
  import pcsu_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   reloc_io_strap_pin,
  input  wire logic   mmio_strap_pin,
  input  wire logic   rom_present_strap_pin,
  input  wire logic   rom_size_strap_pin,
  input  wire logic   interrupt_strap_pin,
  pcsu_strap_if.source straps
);

  // Sample while reset is held, freeze after release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      straps.reloc_en    <= reloc_io_strap_pin;
      straps.mmio        <= mmio_strap_pin;
      straps.rom_present <= rom_present_strap_pin;
      straps.rom_32k     <= rom_size_strap_pin;
      straps.int_dis     <= interrupt_strap_pin;
    end
  end

  AST_STRAP_HOLD: assert property (@(posedge clk) !reset && !$past(reset) |->
    $stable({straps.reloc_en, straps.mmio, straps.rom_present,
             straps.rom_32k, straps.int_dis}))
    else $error("strap latch changed outside reset");

endmodule // pcsu_strap_latch

// file: dv/pcsu_host_model.sv
// Host bridge model issuing configuration reads and writes
`timescale 1ns/100ps
module pcsu_host_model (
  input  wire logic        clk,
  output logic      [7:0]  cfg_addr,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rd_valid
);
  // Idle bus from time zero
  initial
  begin
    cfg_addr  = 8'h00;
    cfg_wr    = 1'h0;
    cfg_rd    = 1'h0;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One write: launched after a falling edge, dropped after the taking edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    cfg_wr    = 1'h1;
    @(negedge clk);
    cfg_wr    = 1'h0;
    cfg_wdata = ~d; // Released data must not look like the last value
  endtask

  // One read; the valid flag stands for one cycle only, so take it then
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd   = 1'h1;
    @(negedge clk);
    cfg_rd   = 1'h0;
    ok       = cfg_rd_valid;
    d        = cfg_rdata;
  endtask
endmodule // pcsu_host_model

// file: dv/pci_config_space_upper_regs_tb.sv
// Self-checking bench for the upper configuration registers
`timescale 1ns/100ps
module pci_config_space_upper_regs_tb;
  import pcsu_pkg::*;
  logic        clk, reset, ext_we, irq_req, cfg_wr, cfg_rd, cfg_rd_valid;
  logic [4:0]  straps;
  logic [15:0] io_addr;
  logic [31:0] mem_addr, cfg_wdata, cfg_rdata, mmio_addr;
  logic [7:0]  cfg_addr, strap_latch;
  logic [3:0]  cfg_be;
  logic        reloc_hit, win_hit, base_hit, dram_block, rom_sel, int_out, int_oe_n;
  int          fail_count;
  int          total_checks;

  pcsu_host_model pcsu_host_model_inst (.clk(clk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid));

  pcsu_top pcsu_top_inst (.clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .ext_write_enable(ext_we),
    .reloc_io_strap_pin(straps[4]), .mmio_strap_pin(straps[3]),
    .rom_present_strap_pin(straps[2]), .rom_size_strap_pin(straps[1]),
    .interrupt_strap_pin(straps[0]), .io_port_addr(io_addr), .mem_addr(mem_addr),
    .irq_request(irq_req), .mmio_mem_addr(mmio_addr), .reloc_io_hit(reloc_hit),
    .rom_window_hit(win_hit), .rom_base_hit(base_hit), .dram_cas_we_block(dram_block),
    .rom_bus_select(rom_sel), .interrupt_request_out(int_out),
    .interrupt_request_out_oe_n(int_oe_n), .strap_latch_register(strap_latch));

  // 10 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    pcsu_host_model_inst.cfg_read(a, d, ok);
    chk_sig({31'h0, ok}, 32'h1, "read answer");
    chk_sig(d, exp, "register read");
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    pcsu_host_model_inst.cfg_write(a, be, d);
  endtask

  // Straps move after release so a latch that keeps sampling shows up
  task automatic do_reset(input logic [4:0] s);
    @(negedge clk);
    reset  = 1'h1;
    straps = s;
    repeat (5) @(negedge clk);
    reset  = 1'h0;
    straps = ~s;
  endtask

  // Decoders lag the cause by at most two edges
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #(2000 * 100);
    fail_count++;
    final_report();
  end

  // Three strap setups: none, all, relocation only
  initial
  begin
    reset = 1'h1;
    ext_we = 1'h0;
    irq_req = 1'h0;
    straps = 5'h00;
    io_addr = 16'h0000;
    mem_addr = 32'h0;
    fail_count = 0;
    total_checks = 0;
    do_reset(5'h00);
    chk_sig({24'h0, strap_latch}, 32'h0, "strap latch");
    chk_reg(8'h14, 32'h0);
    wr(8'h14, 4'hf, 32'hffffffff);
    chk_reg(8'h14, 32'h0000fc00);
    io_addr = 16'hfc00;
    settle();
    chk_sig({31'h0, reloc_hit}, 32'h0, "reloc hit");
    chk_reg(8'h2c, 32'h0);
    wr(8'h2c, 4'hf, 32'h12345678);
    chk_reg(8'h2c, 32'h0);
    ext_we = 1'h1;
    wr(8'h2c, 4'hf, 32'h12345678);
    wr(8'h2c, 4'h1, 32'hffffffff);
    chk_reg(8'h2c, 32'h123456ff);
    chk_reg(8'h30, 32'h0);
    wr(8'h30, 4'hf, 32'hffffffff);
    chk_reg(8'h30, 32'hffff0000);
    mem_addr = 32'h000c0000;
    settle();
    chk_sig({30'h0, dram_block, win_hit}, 32'h0, "rom off");
    chk_reg(8'h3c, 32'h00000100);
    wr(8'h3c, 4'hf, 32'hffffffff);
    chk_reg(8'h3c, 32'h000001ff);
    irq_req = 1'h1;
    settle();
    chk_sig({30'h0, int_oe_n, int_out}, 32'h0, "irq drive");
    wr(8'h40, 4'hf, 32'hffffffff);
    chk_reg(8'h40, 32'h0);
    do_reset(5'h1f);
    chk_sig({24'h0, strap_latch}, 32'h9a, "strap latch");
    chk_reg(8'h30, 32'h000c0000);
    chk_reg(8'h3c, 32'h0);
    chk_reg(8'h2c, 32'h0);
    chk_sig({31'h0, int_oe_n}, 32'h1, "irq off");
    wr(8'h30, 4'hf, 32'h000c8001);
    chk_reg(8'h30, 32'h000c8001);
    mem_addr = 32'h000c8000;
    settle();
    chk_sig({28'h0, dram_block, rom_sel, win_hit, base_hit}, 32'hf, "rom on");
    mem_addr = 32'h000c0000;
    settle();
    chk_sig({30'h0, win_hit, base_hit}, 32'h2, "32k decode");
    wr(8'h30, 4'hf, 32'h000c0001);
    chk_reg(8'h30, 32'h000c0001);
    settle();
    chk_sig({30'h0, win_hit, base_hit}, 32'h3, "64k decode");
    wr(8'h14, 4'hf, 32'haaaabc00);
    chk_reg(8'h14, 32'haaaabc01);
    io_addr = 16'hbfc4;
    settle();
    chk_sig(mmio_addr, 32'haaaabfc4, "mmio address");
    chk_sig({31'h0, reloc_hit}, 32'h0, "reloc hit");
    do_reset(5'h10);
    chk_reg(8'h14, 32'h1);
    wr(8'h14, 4'hf, 32'h0000a401);
    chk_reg(8'h14, 32'h0000a401);
    io_addr = 16'ha5ff;
    settle();
    chk_sig({31'h0, reloc_hit}, 32'h1, "reloc hit");
    io_addr = 16'ha9ff;
    settle();
    chk_sig({31'h0, reloc_hit}, 32'h0, "reloc miss");
    final_report();
  end
endmodule // pci_config_space_upper_regs_tb
